// ===== inc/drive_serial_pkg.sv
// Constants shared by the serial status and gating logic
package drive_serial_pkg;
	localparam int WORD_W = 16;
	localparam int FRAC_W = 14;
	localparam logic [15:0] REF_FULL = 16'h4000;
	localparam logic [15:0] REF_MAX = 16'h7FFF;
	// Status bit positions
	localparam int ST_CTRL_READY = 0;
	localparam int ST_DRIVE_READY = 1;
	localparam int ST_STANDBY = 2;
	localparam int ST_TRIP = 3;
	localparam int ST_WARN = 7;
	localparam int ST_AT_REF = 8;
	localparam int ST_SERIAL_CTRL = 9;
	localparam int ST_IN_RANGE = 10;
	localparam int ST_RUNNING = 11;
	localparam int ST_VOLT_WARN = 13;
	localparam int ST_CUR_LIMIT = 14;
	localparam int ST_THERMAL = 15;
	// Control word bit of the serial coasting command
	localparam int CW_COAST = 3;
	// Source modes
	localparam logic [1:0] SRC_DIGITAL = 2'h0;
	localparam logic [1:0] SRC_SERIAL = 2'h1;
	localparam logic [1:0] SRC_AND = 2'h2;
	localparam logic [1:0] SRC_OR = 2'h3;
	localparam logic [1:0] DC_BRAKE_RESET = 2'h3;
	localparam logic [1:0] COAST_RESET = 2'h0;
	// Protocols
	localparam logic [1:0] PROTO_NATIVE = 2'h0;
	localparam logic [1:0] PROTO_ALT1 = 2'h1;
	localparam logic [1:0] PROTO_ALT2 = 2'h2;
	// Baud codes and rates
	localparam logic [2:0] BAUD_MAX_CODE = 3'h5;
	localparam logic [2:0] BAUD_RESET = 3'h5;
	localparam int BAUD_RATE [6] = '{300, 600, 1200, 2400, 4800, 9600};
	localparam logic [7:0] ADDR_RESET = 8'h01;
	// Clock rate and trip delay counting
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_US = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam logic [7:0] TICK_LOAD = 8'(TICK_CYCLES - 1);
endpackage

// ===== src/source_gate.sv
// Four-mode combiner of a terminal and a serial command
`timescale 1ns/1ps
`default_nettype none
module source_gate (
	input wire logic [1:0] mode,
	input wire logic term_in,
	input wire logic serial_in,
	input wire logic active_low,
	output logic active
);
	logic t;
	logic s;
	// Normalise to active high before combining
	assign t = term_in ^ active_low;
	assign s = serial_in ^ active_low;
	// AND and OR modes combine the active-high actions, the same for either level polarity
	always_comb begin
		unique case (mode)
			drive_serial_pkg::SRC_DIGITAL: active = t;
			drive_serial_pkg::SRC_SERIAL: active = s;
			drive_serial_pkg::SRC_AND: active = active_low ? (t & s) : (t & s);
			drive_serial_pkg::SRC_OR: active = active_low ? (t | s) : (t | s);
		endcase
	end
endmodule
`default_nettype wire

// ===== src/ref_scaler.sv
// Signed reference to span mapping, magnitude times span over 0x4000
`timescale 1ns/1ps
`default_nettype none
module ref_scaler (
	input wire logic [15:0] word_in,
	input wire logic [15:0] span_lo,
	input wire logic [15:0] span_hi,
	output logic [15:0] value,
	output logic negative
);
	logic [15:0] mag;
	logic [16:0] span;
	logic [33:0] prod;
	logic [33:0] sum;
	// Two's complement word; sign selects direction
	assign negative = word_in[15];
	assign mag = word_in[15] ? 16'(~word_in + 16'h0001) : word_in;
	assign span = {1'b0, span_hi} - {1'b0, span_lo};
	// Linear map, fraction of 2^14 keeps the divide free
	assign prod = 34'(mag) * 34'(span);
	assign sum = 34'(span_lo) + (prod >> drive_serial_pkg::FRAC_W);
	// Saturate: up to 200 percent can exceed a 16-bit result
	assign value = (sum > 34'h0FFFF) ? 16'hFFFF : sum[15:0];
endmodule
`default_nettype wire

// ===== src/drive_serial_status_gating.sv
// Status word builder, reference codec and command gating
`timescale 1ns/1ps
`default_nettype none
module drive_serial_status_gating (
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial side
	input wire logic [15:0] serial_ctrl_word,
	input wire logic [15:0] serial_ref_word,
	input wire logic serial_word_valid,
	input wire logic serial_addr_wr,
	input wire logic serial_baud_wr,
	input wire logic [7:0] serial_wr_data,
	// Local control panel settings
	input wire logic panel_wr,
	input wire logic [1:0] panel_protocol,
	input wire logic [7:0] panel_address,
	input wire logic [2:0] panel_baud,
	input wire logic [1:0] panel_coast_mode,
	input wire logic [1:0] panel_dc_brake_mode,
	input wire logic [31:0] panel_trip_delay_us,
	input wire logic local_control_panel_stop,
	input wire logic hand_mode,
	// Terminals
	input wire logic term_coast_n,
	input wire logic term_dc_brake_n,
	// Drive conditions
	input wire logic fault,
	input wire logic trip_reset,
	input wire logic warning_any,
	input wire logic start_cmd,
	input wire logic [15:0] out_freq,
	input wire logic [15:0] freq_low_limit,
	input wire logic [15:0] freq_high_limit,
	input wire logic [15:0] ref_min,
	input wire logic [15:0] ref_max,
	input wire logic [15:0] speed_ref,
	input wire logic dc_link_low,
	input wire logic dc_link_high,
	input wire logic [15:0] out_current,
	input wire logic [15:0] output_current_threshold,
	input wire logic motor_overtemp,
	input wire logic converter_overtemp,
	input wire logic thermistor_overtemp,
	// Outputs
	output logic [15:0] status_word,
	output logic [15:0] out_freq_word,
	output logic [15:0] ref_value,
	output logic reverse_req,
	output logic output_stage_off,
	output logic dc_brake,
	output logic tripped,
	output logic [1:0] protocol_sel,
	output logic [7:0] net_address,
	output logic [2:0] baud_sel,
	output logic [13:0] baud_rate_div10,
	output logic serial_refused
);
	////////////////////////////////////////////////////////////////////////
	// Settings, only the panel may write them
	logic [1:0] coast_mode;
	logic [1:0] dc_mode;
	logic [31:0] trip_delay_us;
	logic serial_allowed;
	logic coast_now;
	logic brake_now;
	logic serial_coast_bit;
	logic serial_brake_bit;
	logic [15:0] ref_scaled;
	logic ref_neg;
	logic over_limit;
	logic trip_delay_done;
	logic reset_q;
	logic [7:0] tick_cnt;
	logic tick;
	logic [31:0] over_us;
	logic [15:0] freq_mag;
	logic [16:0] fspan;
	logic [16:0] foff;
	logic [33:0] fnum;
	logic [33:0] fword;
	logic [15:0] next_status;

	// Serial writes to address and baud are ignored on purpose
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			protocol_sel <= drive_serial_pkg::PROTO_NATIVE;
			net_address <= drive_serial_pkg::ADDR_RESET;
			baud_sel <= drive_serial_pkg::BAUD_RESET;
			coast_mode <= drive_serial_pkg::COAST_RESET;
			dc_mode <= drive_serial_pkg::DC_BRAKE_RESET;
			trip_delay_us <= 32'h0000_0064;
		end else if (panel_wr) begin
			if (panel_protocol <= drive_serial_pkg::PROTO_ALT2) begin
				protocol_sel <= panel_protocol;
			end
			net_address <= panel_address;
			if (panel_baud <= drive_serial_pkg::BAUD_MAX_CODE) begin
				baud_sel <= panel_baud;
			end
			coast_mode <= panel_coast_mode;
			dc_mode <= panel_dc_brake_mode;
			trip_delay_us <= panel_trip_delay_us;
		end
	end

	// Baud rate in tens of bits per second, from the selector
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			baud_rate_div10 <= 14'h03C0;
		end else begin
			baud_rate_div10 <= 14'(drive_serial_pkg::BAUD_RATE[baud_sel] / 10);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial control refused in local operation
	assign serial_allowed = !local_control_panel_stop && !hand_mode;

	// Refused flag marks a serial write that was dropped
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			serial_refused <= 1'b0;
		end else begin
			serial_refused <= serial_addr_wr | serial_baud_wr
				| (serial_word_valid & !serial_allowed);
		end
	end

	// Serial coast and brake bits, taken only from an accepted telegram
	// The word lines are not trusted between telegrams, so the last command is held
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			serial_coast_bit <= 1'b1;
			serial_brake_bit <= 1'b1;
		end else if (serial_word_valid && serial_allowed && serial_ctrl_word[10]) begin
			serial_coast_bit <= serial_ctrl_word[drive_serial_pkg::CW_COAST];
			serial_brake_bit <= serial_ctrl_word[2];
		end
	end

	// Coasting and DC brake combiners, both active low
	source_gate u_coast (
		.mode(coast_mode),
		.term_in(term_coast_n),
		.serial_in(serial_coast_bit | !serial_allowed),
		.active_low(1'b1),
		.active(coast_now)
	);
	source_gate u_brake (
		.mode(dc_mode),
		.term_in(term_dc_brake_n),
		.serial_in(serial_brake_bit | !serial_allowed),
		.active_low(1'b1),
		.active(brake_now)
	);

	// Output stage release and brake request
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			output_stage_off <= 1'b1;
			dc_brake <= 1'b0;
		end else begin
			output_stage_off <= coast_now | tripped;
			dc_brake <= brake_now;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reference decode, latched on an accepted serial word
	ref_scaler u_ref (
		.word_in(serial_ref_word),
		.span_lo(ref_min),
		.span_hi(ref_max),
		.value(ref_scaled),
		.negative(ref_neg)
	);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ref_value <= 16'h0000;
			reverse_req <= 1'b0;
		end else if (serial_word_valid && serial_allowed && serial_ctrl_word[10]) begin
			ref_value <= ref_scaled;
			reverse_req <= ref_neg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Microsecond tick divider for the overcurrent delay
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tick_cnt <= drive_serial_pkg::TICK_LOAD;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == 8'h00);
			tick_cnt <= (tick_cnt == 8'h00) ? drive_serial_pkg::TICK_LOAD : tick_cnt - 8'h01;
		end
	end

	assign over_limit = out_current > output_current_threshold;

	// Time above the limit; drops to zero once current falls back
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			over_us <= 32'h0000_0000;
		end else if (!over_limit) begin
			over_us <= 32'h0000_0000;
		end else if (tick && !trip_delay_done) begin
			over_us <= over_us + 32'h0000_0001;
		end
	end
	assign trip_delay_done = over_limit && (over_us >= trip_delay_us);

	// Trip latch, released only by a rising reset with no fault left
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reset_q <= 1'b0;
			tripped <= 1'b0;
		end else begin
			reset_q <= trip_reset;
			if (fault || trip_delay_done) begin
				tripped <= 1'b1;
			end else if (trip_reset && !reset_q) begin
				tripped <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output frequency word: offset over span, scaled to 0x4000
	assign freq_mag = out_freq;
	assign fspan = {1'b0, freq_high_limit} - {1'b0, freq_low_limit};
	assign foff = (freq_mag > freq_low_limit) ? ({1'b0, freq_mag} - {1'b0, freq_low_limit}) : 17'h00000;
	assign fnum = 34'(foff) << drive_serial_pkg::FRAC_W;
	// Zero span is guarded; the divide is a plain combinational one
	assign fword = (fspan == 17'h00000) ? 34'h0 : fnum / 34'(fspan);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			out_freq_word <= 16'h0000;
		end else begin
			out_freq_word <= (fword > 34'(drive_serial_pkg::REF_MAX)) ? drive_serial_pkg::REF_MAX : fword[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status word assembly
	always_comb begin
		next_status = 16'h0000;
		next_status[drive_serial_pkg::ST_CTRL_READY] = !tripped;
		next_status[drive_serial_pkg::ST_DRIVE_READY] = !tripped && coast_now;
		next_status[drive_serial_pkg::ST_STANDBY] = !tripped && !coast_now;
		next_status[drive_serial_pkg::ST_TRIP] = tripped;
		next_status[drive_serial_pkg::ST_WARN] = warning_any;
		next_status[drive_serial_pkg::ST_AT_REF] = (out_freq == speed_ref);
		next_status[drive_serial_pkg::ST_SERIAL_CTRL] = serial_allowed;
		next_status[drive_serial_pkg::ST_IN_RANGE] = (out_freq > freq_low_limit)
			&& (out_freq < freq_high_limit);
		next_status[drive_serial_pkg::ST_RUNNING] = start_cmd || (out_freq != 16'h0000);
		next_status[drive_serial_pkg::ST_VOLT_WARN] = dc_link_low || dc_link_high;
		next_status[drive_serial_pkg::ST_CUR_LIMIT] = over_limit;
		next_status[drive_serial_pkg::ST_THERMAL] = motor_overtemp || converter_overtemp
			|| thermistor_overtemp;
		// Bits 04..06 and 12 stay zero
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			status_word <= 16'h0000;
		end else begin
			status_word <= next_status;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_unused_zero;
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> (status_word[6:4] == 3'h0) && !status_word[12];
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused status bits set");

	property p_trip_bits;
		@(posedge clk_sys) disable iff (!rst_n)
		tripped |=> status_word[3] && !status_word[0];
	endproperty
	a_trip_bits: assert property (p_trip_bits) else $error("trip bits wrong");

	property p_warn;
		@(posedge clk_sys) disable iff (!rst_n)
		warning_any |=> status_word[7];
	endproperty
	a_warn: assert property (p_warn) else $error("warning bit missing");

	property p_local;
		@(posedge clk_sys) disable iff (!rst_n)
		(local_control_panel_stop || hand_mode) |=> !status_word[9];
	endproperty
	a_local: assert property (p_local) else $error("serial bit set in local");

	property p_running;
		@(posedge clk_sys) disable iff (!rst_n)
		start_cmd |=> status_word[11];
	endproperty
	a_running: assert property (p_running) else $error("running bit missing");

	property p_volt;
		@(posedge clk_sys) disable iff (!rst_n)
		(dc_link_low || dc_link_high) |=> status_word[13];
	endproperty
	a_volt: assert property (p_volt) else $error("voltage bit missing");

	property p_thermal;
		@(posedge clk_sys) disable iff (!rst_n)
		thermistor_overtemp |=> status_word[15];
	endproperty
	a_thermal: assert property (p_thermal) else $error("thermal bit missing");

	property p_coast;
		@(posedge clk_sys) disable iff (!rst_n)
		(coast_mode == drive_serial_pkg::SRC_SERIAL && serial_allowed && !serial_coast_bit)
			|=> output_stage_off;
	endproperty
	a_coast: assert property (p_coast) else $error("coast ignored");

	property p_addr_lock;
		@(posedge clk_sys) disable iff (!rst_n)
		!panel_wr |=> $stable(net_address) && $stable(baud_sel);
	endproperty
	a_addr_lock: assert property (p_addr_lock) else $error("setting changed without panel");

	property p_curlim;
		@(posedge clk_sys) disable iff (!rst_n)
		(out_current > output_current_threshold) |=> status_word[14];
	endproperty
	a_curlim: assert property (p_curlim) else $error("current bit missing");

	property p_brake_or;
		@(posedge clk_sys) disable iff (!rst_n)
		(dc_mode == drive_serial_pkg::SRC_OR && !term_dc_brake_n) |=> dc_brake;
	endproperty
	a_brake_or: assert property (p_brake_or) else $error("terminal brake ignored");

	property p_ref_reverse;
		@(posedge clk_sys) disable iff (!rst_n)
		(serial_word_valid && serial_allowed && serial_ctrl_word[10] && serial_ref_word[15]) |=> reverse_req;
	endproperty
	a_ref_reverse: assert property (p_ref_reverse) else $error("negative reference kept forward");
endmodule
`default_nettype wire

// ===== tb/serial_master.sv
// Serial bus master model: sends control and reference telegrams
`timescale 1ns/1ps
`default_nettype none
module serial_master (
	input wire logic clk_sys,
	input wire logic send,
	input wire logic [15:0] ctrl_in,
	input wire logic neg,
	input wire logic [14:0] mag,
	output logic [15:0] serial_ctrl_word,
	output logic [15:0] serial_ref_word,
	output logic serial_word_valid
);
	initial begin
		serial_ctrl_word = 16'h5A5A;
		serial_ref_word = 16'hA5A5;
		serial_word_valid = 1'b0;
	end
	// Words flip between telegrams so the device never leans on stale levels
	always @(posedge clk_sys) begin
		serial_word_valid <= send;
		if (send) begin
			serial_ctrl_word <= ctrl_in | 16'h0400; // Data valid bit set
			serial_ref_word <= neg ? 16'(~{1'b0, mag} + 16'h0001) : {1'b0, mag};
		end else begin
			serial_ctrl_word <= ~serial_ctrl_word;
			serial_ref_word <= ~serial_ref_word;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the serial status and command gating block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys, rst_n, send, neg, valid, addr_wr, baud_wr, panel_wr, stop, hand, tc_n, brk_n;
	logic fault, trip_reset, warn, start, dcl, dch, ot_m, ot_c, ot_t, rev, off, dcb, trp, refu;
	logic [1:0] proto, cmode, bmode, psel;
	logic [2:0] baud, bsel;
	logic [7:0] addr, wdata, nadr;
	logic [13:0] div10;
	logic [14:0] mag;
	logic [15:0] ctrl, ctrl_w, ref_w, f, lo, hi, rmin, rmax, sref, cur, thr, st, ofw, rv, kref;
	logic [31:0] tdel;
	int errors, checks_done, v, a, n;
	serial_master master (.clk_sys(clk_sys), .send(send), .ctrl_in(ctrl), .neg(neg), .mag(mag),
		.serial_ctrl_word(ctrl_w), .serial_ref_word(ref_w), .serial_word_valid(valid));
	drive_serial_status_gating uut (.clk_sys(clk_sys), .rst_n(rst_n), .serial_ctrl_word(ctrl_w),
		.serial_ref_word(ref_w), .serial_word_valid(valid), .serial_addr_wr(addr_wr),
		.serial_baud_wr(baud_wr), .serial_wr_data(wdata), .panel_wr(panel_wr), .panel_protocol(proto),
		.panel_address(addr), .panel_baud(baud), .panel_coast_mode(cmode), .panel_dc_brake_mode(bmode),
		.panel_trip_delay_us(tdel), .local_control_panel_stop(stop), .hand_mode(hand),
		.term_coast_n(tc_n), .term_dc_brake_n(brk_n), .fault(fault), .trip_reset(trip_reset),
		.warning_any(warn), .start_cmd(start), .out_freq(f), .freq_low_limit(lo), .freq_high_limit(hi),
		.ref_min(rmin), .ref_max(rmax), .speed_ref(sref), .dc_link_low(dcl), .dc_link_high(dch),
		.out_current(cur), .output_current_threshold(thr), .motor_overtemp(ot_m),
		.converter_overtemp(ot_c), .thermistor_overtemp(ot_t), .status_word(st), .out_freq_word(ofw),
		.ref_value(rv), .reverse_req(rev), .output_stage_off(off), .dc_brake(dcb), .tripped(trp),
		.protocol_sel(psel), .net_address(nadr), .baud_sel(bsel), .baud_rate_div10(div10),
		.serial_refused(refu));
	////////////////////////////////////////////////////////////////////////////////
	// Clock, 5 ns period
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Watchdog, far beyond the expected run of some 5 us
	initial begin
		#200000;
		errors++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		if (errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	// Panel load of every setting at once
	task automatic pset(input logic [1:0] p, input logic [7:0] ad, input logic [2:0] b, input logic [1:0] m);
		@(posedge clk_sys);
		{proto, addr, baud, cmode, bmode, panel_wr} <= {p, ad, b, m, m, 1'b1};
		@(posedge clk_sys);
		panel_wr <= 1'b0;
		wt(2);
	endtask
	// Raise one telegram; the caller finishes it
	task automatic tx(input logic [15:0] c, input logic ng, input logic [14:0] m);
		@(posedge clk_sys);
		{ctrl, neg, mag, send} <= {c, ng, m, 1'b1};
	endtask
	task automatic tx_done;
		@(posedge clk_sys);
		send <= 1'b0;
		wt(3);
	endtask
	// A refused request must give exactly one refusal pulse
	task automatic refuse_chk;
		n = 0;
		repeat (6) begin
			@(posedge clk_sys);
			{addr_wr, baud_wr, send} <= 3'h0;
			#1;
			if (refu === 1'b1) n++;
		end
		chk_word(16'(n), 16'h0001);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] exp_status(input logic tr);
		logic [15:0] s;
		s = 16'h0000;
		s[0] = !tr;
		s[1] = !tr && !tc_n;
		s[2] = !tr && tc_n;
		s[3] = tr;
		s[7] = warn;
		s[8] = f == sref;
		s[9] = !(stop || hand);
		s[10] = f > lo && f < hi;
		s[11] = start || f != 16'h0000;
		s[13] = dcl || dch;
		s[14] = cur > thr;
		s[15] = ot_m || ot_c || ot_t;
		return s;
	endfunction
	function automatic logic [15:0] exp_ofw;
		int q;
		q = int'(f - lo) * 16384 / int'(hi - lo);
		return q > 32767 ? 16'h7FFF : 16'(q);
	endfunction
	function automatic logic [15:0] exp_ref(input logic [14:0] m);
		longint q;
		q = longint'(m) * (rmax - rmin) / 16384 + rmin;
		return q > 65535 ? 16'hFFFF : 16'(q);
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{send, addr_wr, baud_wr, panel_wr, stop, hand, fault, trip_reset, warn, start} = 10'h000;
		{dcl, dch, ot_m, ot_c, ot_t, neg, rst_n, tc_n, brk_n} = 9'h003;
		{proto, cmode, bmode, baud, addr, wdata, mag} = {2'h0, 2'h0, 2'h3, 3'h5, 8'h01, 8'h00, 15'h0000};
		{ctrl, f, lo, hi, rmin, rmax, sref, cur, thr} = {16'h0400, 16'h0000, 16'h0000, 16'd500,
			16'h0000, 16'h4000, 16'h0001, 16'h0000, 16'h8000};
		tdel = 32'h0000_0002;
		v = $urandom(32'h6ab2);
		wt(8);
		rst_n <= 1'b1;
		wt(3);
		// Defaults after reset
		chk_word({14'h0000, psel}, 16'h0000);
		chk_word({8'h00, nadr}, {8'h00, drive_serial_pkg::ADDR_RESET});
		chk_word({13'h0000, bsel}, 16'h0005);
		chk_word({2'h0, div10}, 16'd960);
		chk_bit(dcb, 1'b0);
		chk_bit(off, 1'b0);
		// Random status conditions, frequency word alongside
		for (int i = 0; i < 40; i++) begin
			a = ($urandom % 4 == 0) ? 0 : $urandom % 1000;
			@(posedge clk_sys);
			{warn, start, dcl, dch, ot_m, ot_c, ot_t, stop, hand, tc_n} <= 10'($urandom);
			f <= 16'(a);
			sref <= ($urandom % 2) ? 16'(a) : 16'($urandom % 1000);
			cur <= 16'($urandom % 1000);
			thr <= 16'($urandom % 1000);
			wt(3);
			chk_word(st, exp_status(1'b0));
			chk_word(ofw, exp_ofw());
		end
		@(posedge clk_sys);
		{stop, hand, tc_n, cur, thr} <= {3'h1, 16'h0000, 16'h8000};
		// Reference decoding: corners first, then random
		a = $urandom % 1000;
		@(posedge clk_sys);
		rmin <= 16'(a);
		rmax <= 16'(a + $urandom % 50000);
		for (int i = 0; i < 34; i++) begin
			case (i)
				0: {neg, mag} = {1'b0, 15'h0000};
				1: {neg, mag} = {1'b0, 15'h4000};
				2: {neg, mag} = {1'b1, 15'h2000};
				3: {neg, mag} = {1'b1, 15'h7FFF};
				default: {neg, mag} = {1'b0, 15'($urandom)};
			endcase
			if (i > 3 && mag != 15'h0000) neg = 1'($urandom);
			tx(16'h0000 | 16'h0008, neg, mag);
			tx_done();
			chk_word(rv, exp_ref(mag));
			chk_bit(rev, neg);
		end
		// Telegram refused under panel stop, reference kept
		@(posedge clk_sys);
		stop <= 1'b1;
		wt(2);
		chk_bit(st[9], 1'b0);
		kref = exp_ref(mag);
		tx(16'h000C, 1'b0, 15'h1234);
		refuse_chk();
		chk_word(rv, kref);
		@(posedge clk_sys);
		stop <= 1'b0;
		// Serial address and baud writes refused
		@(posedge clk_sys);
		{addr_wr, wdata} <= {1'b1, 8'h7E};
		refuse_chk();
		chk_word({8'h00, nadr}, 16'h0001);
		@(posedge clk_sys);
		{baud_wr, wdata} <= {1'b1, 8'h00};
		refuse_chk();
		chk_word({13'h0000, bsel}, 16'h0005);
		// Every protocol and baud code through the panel
		for (int b = 0; b < 6; b++) begin
			pset(2'(b % 3), 8'h22, 3'(b), 2'h0);
			chk_word({14'h0000, psel}, 16'(b % 3));
			chk_word({13'h0000, bsel}, 16'(b));
			chk_word({2'h0, div10}, 16'(drive_serial_pkg::BAUD_RATE[b] / 10));
			chk_word({8'h00, nadr}, 16'h0022);
		end
		pset(2'h3, 8'h22, 3'h6, 2'h0);
		chk_word({14'h0000, psel}, 16'h0002);
		chk_word({13'h0000, bsel}, 16'h0005);
		// All source modes against terminal and serial bit
		for (int i = 0; i < 16; i++) begin
			pset(2'h0, 8'h22, 3'h5, 2'(i >> 2));
			@(posedge clk_sys);
			{tc_n, brk_n} <= {2{i[1]}};
			tx(16'({i[0], i[0], 2'h0}), 1'b0, 15'h0000);
			tx_done();
			case (i >> 2)
				0: v = !i[1];
				1: v = !i[0];
				2: v = !i[1] && !i[0];
				default: v = !i[1] || !i[0];
			endcase
			chk_bit(off, 1'(v));
			chk_bit(dcb, 1'(v));
		end
		// Overcurrent trip after the 2 us delay, then reset
		@(posedge clk_sys);
		{cur, thr, f, sref} <= {16'd900, 16'd500, 16'd100, 16'd100};
		wt(150);
		chk_bit(trp, 1'b0);
		chk_bit(st[14], 1'b1);
		n = 0;
		while (trp !== 1'b1 && n < 800) begin
			wt(1);
			n++;
		end
		chk_bit(trp, 1'b1);
		wt(1);
		chk_word(st, exp_status(1'b1));
		@(posedge clk_sys);
		{cur, trip_reset} <= {16'h0000, 1'b1};
		@(posedge clk_sys);
		trip_reset <= 1'b0;
		wt(4);
		chk_bit(trp, 1'b0);
		chk_word(st, exp_status(1'b0));
		@(posedge clk_sys);
		fault <= 1'b1;
		wt(4);
		chk_word(st, exp_status(1'b1));
		wrap_up();
	end
endmodule
`default_nettype wire
